// *** inc/dsp_regs.svh ***
`ifndef DSP_REGS_SVH
`define DSP_REGS_SVH

// ****************************************
// Clock and rounding
// ****************************************
`define DSP_TCK_PS 8000
// Least times round up to whole cycles
`define DSP_CYC(ps) (((ps) + `DSP_TCK_PS - 1) / `DSP_TCK_PS)

// ****************************************
// Spacing times in picoseconds
// ****************************************
`define DSP_T_RRD_PS 10000
`define DSP_T_FAW_PS 45000
`define DSP_T_WR_PS 15000
`define DSP_T_RP_PS 13125
`define DSP_T_WTR_PS 7500
`define DSP_T_RTP_PS 7500
`define DSP_T_RFC_PS 105000
`define DSP_T_XSNR_ADD_PS 10000
`define DSP_T_IS_PS 125
`define DSP_T_IH_PS 200

// ****************************************
// Spacing counts in clock cycles
// ****************************************
`define DSP_RRD_MIN_CK 2
`define DSP_CCD_CK 2
`define DSP_XSRD_CK 200
`define DSP_XP_CK 3
`define DSP_XARD_CK 3
`define DSP_XARDS_BASE_CK 10
`define DSP_CKE_CK 3
`define DSP_ANPD_CK 4
`define DSP_AXPD_CK 11
`define DSP_MRD_CK 2

// ****************************************
// Mode register fields
// ****************************************
`define DSP_BA_MR 2'h0
`define DSP_BA_EMR 2'h1
`define DSP_MR_SLOWPD_BIT 12
`define DSP_EMR_DQSDIS_BIT 10
`define DSP_AP_BIT 10

// ****************************************
// Pin codes {cs_n, ras_n, cas_n, we_n}
// ****************************************
`define DSP_PIN_NOP 4'h7
`define DSP_PIN_ACT 4'h3
`define DSP_PIN_RD 4'h5
`define DSP_PIN_WR 4'h4
`define DSP_PIN_PRE 4'h2
`define DSP_PIN_REF 4'h1
`define DSP_PIN_MRS 4'h0
`define DSP_PIN_DES 4'hf

`endif

// *** inc/dsp_pkg.sv ***
`default_nettype none

package dsp_pkg;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ACT = 4'h1,
    CMD_RD = 4'h2,
    CMD_WR = 4'h3,
    CMD_PRE = 4'h4,
    CMD_REF = 4'h5,
    CMD_MRS = 4'h6,
    CMD_SRE = 4'h7,
    CMD_SRX = 4'h8,
    CMD_PDE = 4'h9,
    CMD_PDX = 4'ha
  } dsp_cmd_t;

  typedef enum logic [2:0] {
    PS_ACT = 3'h1,
    PS_PD = 3'h2,
    PS_SR = 3'h4
  } dsp_pstate_t;

  typedef struct packed {
    dsp_cmd_t cmd;
    logic ap;
    logic [1:0] ba;
    logic [13:0] a;
  } dsp_req_t;

  typedef struct packed {
    logic ck_run;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [13:0] a;
    logic odt;
  } dsp_pins_t;

endpackage

`default_nettype wire

// *** rtl/dsp_gap_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

// Down counter; a load only lengthens the wait, never shortens it
module dsp_gap_timer #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [W-1:0] val,
  output logic idle
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  always_comb begin
    if (load && (val > cnt_r)) begin
      cnt_nxt = val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign idle = (cnt_r == '0);

endmodule // dsp_gap_timer

`default_nettype wire

// *** rtl/dsp_ctrl.sv ***
// Behaviour
// - Activates at least 10 ns apart, never under two cycles.
// - At most four activates in any rolling 45 ns window.
// - Column commands at least two cycles apart.
// - 15 ns write recovery before precharge; auto-precharge adds precharge.
// - 7.5 ns from internal write end to a read.
// - 7.5 ns from internal read to precharge of that bank.
// - Self refresh exit: refresh cycle plus 10 ns before non-reads.
// - Self refresh exit: 200 cycles before any read.
// - Precharge power-down exit: three cycles before non-reads.
// - Fast active power-down exit: three cycles before a read.
// - Slow active power-down exit: ten minus additive latency to read.
// - Clock enable held at least three cycles at each level.
// - Termination input stable four cycles before power-down entry.
// - Termination timing trusted only eleven cycles after power-down exit.
// - Clock keeps running briefly after clock enable drops.
// - Strobe mode chosen by extended mode register bit.
// - Mode register bit 12 picks fast or slow active exit.
// - Mode register set at least two cycles from next command.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_regs.svh"

module dsp_ctrl #(
  parameter int CL = 7,
  parameter int AL = 0,
  parameter int BL = 4
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire dsp_pkg::dsp_req_t req,
  input wire logic odt_req,
  input wire logic pd_slow_exit,
  input wire logic dqs_diff,
  output logic req_ready,
  output logic done,
  output logic rej,
  output logic odt_sync_ok,
  output dsp_pkg::dsp_pins_t pins
);
  import dsp_pkg::*;

  function automatic int imax(input int x, input int y);
    return (x > y) ? x : y;
  endfunction

  // Timer load value for a gap of g cycles between issues
  function automatic logic [7:0] lv(input int g);
    return 8'(imax(g, 1) - 1);
  endfunction

  function automatic logic [3:0] pin_code(input dsp_cmd_t c);
    case (c)
      CMD_ACT: pin_code = `DSP_PIN_ACT;
      CMD_RD: pin_code = `DSP_PIN_RD;
      CMD_WR: pin_code = `DSP_PIN_WR;
      CMD_PRE: pin_code = `DSP_PIN_PRE;
      CMD_REF, CMD_SRE: pin_code = `DSP_PIN_REF;
      CMD_MRS: pin_code = `DSP_PIN_MRS;
      default: pin_code = `DSP_PIN_NOP;
    endcase
  endfunction

  function automatic logic st_ok(input dsp_cmd_t c, input dsp_pstate_t s);
    case (c)
      CMD_NOP: st_ok = 1'b1;
      CMD_SRX: st_ok = (s == PS_SR);
      CMD_PDX: st_ok = (s == PS_PD);
      default: st_ok = (s == PS_ACT);
    endcase
  endfunction

  // ****************************************
  // Gaps in cycles
  // ****************************************
  // rounding up
  localparam int G_RRD = imax(`DSP_CYC(`DSP_T_RRD_PS), `DSP_RRD_MIN_CK);
  localparam int G_FAW = `DSP_CYC(`DSP_T_FAW_PS);
  localparam int G_WR = `DSP_CYC(`DSP_T_WR_PS);
  localparam int G_RP = `DSP_CYC(`DSP_T_RP_PS);
  localparam int G_WTR = `DSP_CYC(`DSP_T_WTR_PS);
  localparam int G_RTP = `DSP_CYC(`DSP_T_RTP_PS);
  localparam int G_RFC = `DSP_CYC(`DSP_T_RFC_PS);
  localparam int G_XSNR = `DSP_CYC(`DSP_T_RFC_PS + `DSP_T_XSNR_ADD_PS);
  localparam int G_CKH =
    `DSP_CYC(`DSP_T_IS_PS + `DSP_TCK_PS + `DSP_T_IH_PS);
  localparam int G_XARDS = imax(`DSP_XARDS_BASE_CK - AL, 1);
  localparam int WEND = AL + CL - 1 + BL / 2;
  localparam int G_RDPRE = AL + imax(BL / 2, G_RTP);

  localparam int T_PRE = 0;
  localparam int T_ACT = 4;
  localparam int T_FAW = 8;
  localparam int T_RRD = 12;
  localparam int T_CCD = 13;
  localparam int T_WTR = 14;
  localparam int T_MRD = 15;
  localparam int T_NRD = 16;
  localparam int T_RDX = 17;
  localparam int T_CKE = 18;
  localparam int T_ODT = 19;
  localparam int T_AXPD = 20;
  localparam int T_CKH = 21;
  localparam int NT = 22;

  localparam dsp_pins_t PINS_RST = '{ck_run: 1'b1, cke: 1'b1, cs_n: 1'b1,
    ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 2'h0, a: 14'h0, odt: 1'b0};

  logic [NT-1:0] ld;
  logic [NT-1:0] idle;
  logic [7:0] val [NT];

  // ****************************************
  // Spacing timers
  // ****************************************
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    dsp_gap_timer #(.W(8)) u_tmr (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .load(ld[i]),
      .val(val[i]),
      .idle(idle[i])
    );
  end

  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic rej_r, rej_nxt;
  logic sync_r, sync_nxt;
  logic pend_v_r, pend_v_nxt;
  dsp_req_t pend_r, pend_nxt;
  dsp_pstate_t ps_r, ps_nxt;
  logic [3:0] open_r, open_nxt;
  logic slow_r, slow_nxt;
  dsp_cmd_t iss_r, iss_nxt;
  dsp_pins_t pin_r, pin_nxt;
  logic legal, issue;
  logic [1:0] faw_slot;
  int b;

  assign b = int'(pend_r.ba);

  always_comb begin
    faw_slot = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (idle[T_FAW+i]) begin
        faw_slot = 2'(i);
      end
    end
  end

  // ****************************************
  // Command legality
  // ****************************************
  always_comb begin
    case (pend_r.cmd)
      CMD_NOP: legal = 1'b1;
      CMD_ACT: legal = idle[T_ACT+b] && idle[T_RRD] && idle[T_NRD] &&
        (|idle[T_FAW+3:T_FAW]);
      CMD_RD: legal = idle[T_CCD] && idle[T_WTR] && idle[T_RDX];
      CMD_WR: legal = idle[T_CCD] && idle[T_NRD];
      CMD_PRE: legal = idle[T_NRD] &&
        (pend_r.ap ? (&idle[T_PRE+3:T_PRE]) : idle[T_PRE+b]);
      CMD_REF: legal = idle[T_NRD] && (&idle[T_ACT+3:T_ACT]);
      CMD_MRS: legal = idle[T_NRD];
      CMD_SRE, CMD_PDE: legal = idle[T_CKE] && idle[T_ODT] &&
        idle[T_NRD] && (odt_req == pin_r.odt);
      CMD_SRX: legal = idle[T_CKE] && pin_r.ck_run;
      CMD_PDX: legal = idle[T_CKE];
      default: legal = 1'b0;
    endcase
    legal = legal && idle[T_MRD] && st_ok(pend_r.cmd, ps_r);
  end

  assign issue = pend_v_r && legal;

  // ****************************************
  // Timer loads
  // ****************************************
  always_comb begin
    ld = '0;
    for (int i = 0; i < NT; i++) begin
      val[i] = 8'h00;
    end
    if (pin_nxt.odt != pin_r.odt) begin
      ld[T_ODT] = 1'b1;
      val[T_ODT] = lv(`DSP_ANPD_CK);
    end
    if (issue) begin
      case (pend_r.cmd)
        CMD_ACT: begin
          ld[T_RRD] = 1'b1;
          val[T_RRD] = lv(G_RRD);
          ld[T_FAW+int'(faw_slot)] = 1'b1;
          val[T_FAW+int'(faw_slot)] = lv(G_FAW);
        end
        CMD_RD: begin
          ld[T_CCD] = 1'b1;
          val[T_CCD] = lv(`DSP_CCD_CK);
          ld[T_PRE+b] = 1'b1;
          val[T_PRE+b] = lv(G_RDPRE);
          ld[T_ACT+b] = pend_r.ap;
          val[T_ACT+b] = lv(G_RDPRE + G_RP);
        end
        CMD_WR: begin
          ld[T_CCD] = 1'b1;
          val[T_CCD] = lv(`DSP_CCD_CK);
          ld[T_PRE+b] = 1'b1;
          val[T_PRE+b] = lv(WEND + G_WR);
          ld[T_ACT+b] = pend_r.ap;
          val[T_ACT+b] = lv(WEND + G_WR + G_RP);
          ld[T_WTR] = 1'b1;
          val[T_WTR] = lv(WEND + G_WTR);
        end
        CMD_PRE: begin
          for (int k = 0; k < 4; k++) begin
            ld[T_ACT+k] = pend_r.ap || (k == b);
            val[T_ACT+k] = lv(G_RP);
          end
        end
        CMD_REF: begin
          ld[T_NRD] = 1'b1;
          val[T_NRD] = lv(G_RFC);
          ld[T_RDX] = 1'b1;
          val[T_RDX] = lv(G_RFC);
        end
        CMD_MRS: begin
          ld[T_MRD] = 1'b1;
          val[T_MRD] = lv(`DSP_MRD_CK);
        end
        CMD_SRE, CMD_PDE: begin
          ld[T_CKE] = 1'b1;
          val[T_CKE] = lv(`DSP_CKE_CK);
          ld[T_CKH] = 1'b1;
          val[T_CKH] = lv(G_CKH);
        end
        CMD_SRX: begin
          ld[T_CKE] = 1'b1;
          val[T_CKE] = lv(`DSP_CKE_CK);
          ld[T_NRD] = 1'b1;
          val[T_NRD] = lv(G_XSNR);
          ld[T_RDX] = 1'b1;
          val[T_RDX] = lv(`DSP_XSRD_CK);
          ld[T_AXPD] = 1'b1;
          val[T_AXPD] = lv(`DSP_AXPD_CK);
        end
        CMD_PDX: begin
          ld[T_CKE] = 1'b1;
          val[T_CKE] = lv(`DSP_CKE_CK);
          ld[T_NRD] = 1'b1;
          val[T_NRD] = lv(`DSP_XP_CK);
          ld[T_RDX] = 1'b1;
          if (open_r == 4'h0) begin
            val[T_RDX] = lv(`DSP_XP_CK);
          end else if (slow_r) begin
            val[T_RDX] = lv(G_XARDS);
          end else begin
            val[T_RDX] = lv(`DSP_XARD_CK);
          end
          ld[T_AXPD] = 1'b1;
          val[T_AXPD] = lv(`DSP_AXPD_CK);
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Request, state and pins
  // ****************************************
  always_comb begin
    pend_v_nxt = pend_v_r;
    pend_nxt = pend_r;
    if (issue || (pend_v_r && !st_ok(pend_r.cmd, ps_r))) begin
      pend_v_nxt = 1'b0;
    end
    if (req_valid && ready_r) begin
      pend_v_nxt = 1'b1;
      pend_nxt = req;
    end
    ready_nxt = !pend_v_nxt;
    done_nxt = issue;
    rej_nxt = pend_v_r && !st_ok(pend_r.cmd, ps_r);
    sync_nxt = idle[T_AXPD] && !(issue &&
      (pend_r.cmd == CMD_SRX || pend_r.cmd == CMD_PDX));
    ps_nxt = ps_r;
    open_nxt = open_r;
    slow_nxt = slow_r;
    iss_nxt = issue ? pend_r.cmd : CMD_NOP;
    pin_nxt = pin_r;
    {pin_nxt.cs_n, pin_nxt.ras_n, pin_nxt.cas_n, pin_nxt.we_n} =
      `DSP_PIN_NOP;
    pin_nxt.odt = odt_req;
    // clock stops only after the hold in self refresh
    pin_nxt.ck_run = !(ps_r == PS_SR && idle[T_CKH] &&
      !(pend_v_r && pend_r.cmd == CMD_SRX));
    if (issue) begin
      {pin_nxt.cs_n, pin_nxt.ras_n, pin_nxt.cas_n, pin_nxt.we_n} =
        pin_code(pend_r.cmd);
      pin_nxt.ba = pend_r.ba;
      pin_nxt.a = pend_r.a;
      case (pend_r.cmd)
        CMD_ACT: open_nxt[b] = 1'b1;
        CMD_RD, CMD_WR: begin
          pin_nxt.a[`DSP_AP_BIT] = pend_r.ap;
          if (pend_r.ap) begin
            open_nxt[b] = 1'b0;
          end
        end
        CMD_PRE: begin
          pin_nxt.a[`DSP_AP_BIT] = pend_r.ap;
          open_nxt = pend_r.ap ? 4'h0 : (open_r & ~(4'h1 << b));
        end
        CMD_MRS: begin
          if (pend_r.ba == `DSP_BA_MR) begin
            pin_nxt.a[`DSP_MR_SLOWPD_BIT] = pd_slow_exit;
            slow_nxt = pd_slow_exit;
          end
          if (pend_r.ba == `DSP_BA_EMR) begin
            pin_nxt.a[`DSP_EMR_DQSDIS_BIT] = !dqs_diff;
          end
        end
        CMD_SRE: begin
          pin_nxt.cke = 1'b0;
          ps_nxt = PS_SR;
        end
        CMD_PDE: begin
          pin_nxt.cke = 1'b0;
          ps_nxt = PS_PD;
        end
        CMD_SRX, CMD_PDX: begin
          pin_nxt.cke = 1'b1;
          ps_nxt = PS_ACT;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ready_r <= 1'b1;
      done_r <= 1'b0;
      rej_r <= 1'b0;
      sync_r <= 1'b1;
      pend_v_r <= 1'b0;
      pend_r <= '0;
      ps_r <= PS_ACT;
      open_r <= 4'h0;
      slow_r <= 1'b0;
      iss_r <= CMD_NOP;
      pin_r <= PINS_RST;
    end else begin
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      rej_r <= rej_nxt;
      sync_r <= sync_nxt;
      pend_v_r <= pend_v_nxt;
      pend_r <= pend_nxt;
      ps_r <= ps_nxt;
      open_r <= open_nxt;
      slow_r <= slow_nxt;
      iss_r <= iss_nxt;
      pin_r <= pin_nxt;
    end
  end

  assign req_ready = ready_r;
  assign done = done_r;
  assign rej = rej_r;
  assign odt_sync_ok = sync_r;
  assign pins = pin_r;

  // ****************************************
  // Checks
  // ****************************************
  logic [7:0] wr_age_r, wr_age_nxt, srx_age_r, srx_age_nxt;
  logic [7:0] odt_age_r, odt_age_nxt;
  logic [4:0] act_hist_r, act_hist_nxt;
  logic act_p, col_p, rd_p;

  assign act_p = (iss_r == CMD_ACT);
  assign rd_p = (iss_r == CMD_RD);
  assign col_p = rd_p || (iss_r == CMD_WR);

  always_comb begin
    wr_age_nxt = (iss_nxt == CMD_WR) ? 8'h00 :
      ((wr_age_r == 8'hff) ? wr_age_r : wr_age_r + 8'h01);
    srx_age_nxt = (iss_nxt == CMD_SRX) ? 8'h00 :
      ((srx_age_r == 8'hff) ? srx_age_r : srx_age_r + 8'h01);
    odt_age_nxt = (pin_nxt.odt != pin_r.odt) ? 8'h00 :
      ((odt_age_r == 8'hff) ? odt_age_r : odt_age_r + 8'h01);
    act_hist_nxt = {act_hist_r[3:0], act_p};
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wr_age_r <= 8'hff;
      srx_age_r <= 8'hff;
      odt_age_r <= 8'hff;
      act_hist_r <= 5'h00;
    end else begin
      wr_age_r <= wr_age_nxt;
      srx_age_r <= srx_age_nxt;
      odt_age_r <= odt_age_nxt;
      act_hist_r <= act_hist_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  act_spacing_a: assert property (act_p |=> !act_p)
    else $error("activates closer than two cycles");
  act_window_a: assert property ($countones({act_hist_r, act_p}) <= 4)
    else $error("more than four activates in window");
  col_spacing_a: assert property (col_p |=> !col_p)
    else $error("column commands back to back");
  wr_rd_gap_a: assert property (rd_p |-> wr_age_r >= WEND + G_WTR)
    else $error("read too soon after write");
  sr_read_a: assert property (rd_p |-> srx_age_r >= 200)
    else $error("read too soon after self refresh exit");
  sr_nonread_a: assert property (
    (col_p && !rd_p || act_p || iss_r == CMD_MRS) |-> srx_age_r >= G_XSNR)
    else $error("command too soon after self refresh exit");
  cke_pulse_a: assert property (
    $changed(pin_r.cke) |=> $stable(pin_r.cke) [*2])
    else $error("clock enable pulse too short");
  odt_pd_a: assert property ($fell(pin_r.cke) |-> odt_age_r >= 4)
    else $error("power-down entry too soon after termination change");
  odt_sync_a: assert property ($rose(pin_r.cke) |-> !sync_r [*8])
    else $error("termination timing flagged too early");
  ck_hold_a: assert property ($fell(pin_r.cke) |-> pin_r.ck_run [*2])
    else $error("clock stopped too soon after enable drop");
  mrs_gap_a: assert property (iss_r == CMD_MRS |=> iss_r == CMD_NOP)
    else $error("command right after mode set");

  act_seen_c: cover property (act_p ##2 act_p);
  sr_exit_c: cover property (iss_r == CMD_SRX ##[1:300] rd_p);
  pd_exit_c: cover property (iss_r == CMD_PDX ##[1:20] rd_p);
  rej_c: cover property (rej_r);

endmodule // dsp_ctrl

`default_nettype wire

// *** test/dsp_dev_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dsp_regs.svh"

// ****************************************
// Device seen at the command pins
// ****************************************
module dsp_dev_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire dsp_pkg::dsp_pins_t pins,
  output logic slow_exit,
  output logic dqs_single,
  output logic [7:0] viol
);
  import dsp_pkg::*;
  int n;
  int t_act;
  int t_col;
  int t_mrs;
  int t_cke;
  logic cke_q;
  logic live;
  logic col;
  logic bad;
  logic [3:0] code;

  assign code = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
  // Enable must be high on two edges for a command to count
  assign live = pins.ck_run && pins.cke && cke_q && !pins.cs_n &&
    code != `DSP_PIN_NOP;
  assign col = code == `DSP_PIN_RD || code == `DSP_PIN_WR;

  always_comb begin
    bad = 1'b0;
    if (pins.cke != cke_q && n - t_cke < 3) bad = 1'b1;
    if (live && n - t_mrs < 2) bad = 1'b1;
    if (live && code == `DSP_PIN_ACT && n - t_act < 2) bad = 1'b1;
    if (live && col && n - t_col < 2) bad = 1'b1;
  end

  // Counts every edge so a stopped clock cannot hide a short pulse
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      n <= 0;
      t_act <= -100;
      t_col <= -100;
      t_mrs <= -100;
      t_cke <= -100;
      cke_q <= 1'b1;
      viol <= 8'h00;
      slow_exit <= 1'b0;
      dqs_single <= 1'b0;
    end else begin
      n <= n + 1;
      cke_q <= pins.cke;
      viol <= viol + {7'h00, bad};
      if (pins.cke != cke_q) t_cke <= n;
      if (live && code == `DSP_PIN_ACT) t_act <= n;
      if (live && col) t_col <= n;
      if (live && code == `DSP_PIN_MRS) begin
        t_mrs <= n;
        if (pins.ba == `DSP_BA_MR) slow_exit <= pins.a[`DSP_MR_SLOWPD_BIT];
        if (pins.ba == `DSP_BA_EMR) dqs_single <= pins.a[`DSP_EMR_DQSDIS_BIT];
      end
    end
  end
endmodule // dsp_dev_model

`default_nettype wire

// *** test/dsp_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dsp_regs.svh"

module dsp_ctrl_tb;
  import dsp_pkg::*;
  localparam int CL = 7;
  localparam int AL = 0;
  localparam int BL = 4;
  localparam int WL = AL + CL - 1;
  localparam int TCK = `DSP_TCK_PS;
  localparam int WTR = (`DSP_T_WTR_PS + TCK - 1) / TCK;
  localparam int RTP = (`DSP_T_RTP_PS + TCK - 1) / TCK;
  localparam int WR = (`DSP_T_WR_PS + TCK - 1) / TCK;
  localparam int RP = (`DSP_T_RP_PS + TCK - 1) / TCK;
  localparam int FAW = (`DSP_T_FAW_PS + TCK - 1) / TCK;
  localparam int XSNR = (`DSP_T_RFC_PS + 10000 + TCK - 1) / TCK;
  localparam int RFC = (`DSP_T_RFC_PS + TCK - 1) / TCK;
  logic ref_clk, rstn, req_valid, odt_req, pd_slow_exit, dqs_diff;
  logic req_ready, done, rej, odt_sync_ok, slow_exit, dqs_single;
  logic got_rej;
  logic cke_q = 1'b1;
  logic odt_q = 1'b0;
  logic [7:0] viol;
  dsp_req_t req;
  dsp_pins_t pins;
  dsp_pins_t p;
  int failures, num_checks, cyc, t_last, t_now;
  int t_odt = -100;
  int t_cke = -100;
  int t_up = -100;

  dsp_ctrl #(.CL(CL), .AL(AL), .BL(BL)) dsp_ctrl_inst (
    .ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .odt_req(odt_req), .pd_slow_exit(pd_slow_exit), .dqs_diff(dqs_diff),
    .req_ready(req_ready), .done(done), .rej(rej),
    .odt_sync_ok(odt_sync_ok), .pins(pins));

  dsp_dev_model dsp_dev_model_inst (.ref_clk(ref_clk), .rstn(rstn),
    .pins(pins), .slow_exit(slow_exit), .dqs_single(dqs_single),
    .viol(viol));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Request driver and spacing helpers
  // ****************************************
  task automatic issue(input dsp_cmd_t c, input logic [1:0] ba,
                       input logic ap);
    int i;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{cmd: c, ap: ap, ba: ba, a: 14'h0};
    for (i = 0; i < 50; i++) begin
      @(negedge ref_clk);
      if (req_ready === 1'b1) break;
    end
    if (i == 50) begin
      failures++;
      finish_test();
    end
    @(posedge ref_clk);
    req_valid <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(negedge ref_clk);
      if (done === 1'b1 || rej === 1'b1) break;
    end
    if (i == 400) begin
      failures++;
      finish_test();
    end
    got_rej = rej;
    p = pins;
    t_last = t_now;
    t_now = cyc;
  endtask

  task automatic gap_min(input int n);
    check(t_now - t_last >= n, 1'b1);
  endtask

  // Enable, termination and clock-gate watch on every cycle
  always @(negedge ref_clk) begin
    if (rstn === 1'b1 && pins.odt !== odt_q) t_odt = cyc;
    odt_q = pins.odt;
    if (rstn === 1'b1 && pins.cke !== cke_q) begin
      check(cyc - t_cke >= 3, 1'b1);
      t_cke = cyc;
      if (pins.cke === 1'b1) t_up = cyc;
    end
    cke_q = pins.cke;
    if (cyc - t_up == 10) check(odt_sync_ok, 1'b0);
    if (cyc - t_up == 11) check(odt_sync_ok, 1'b1);
    if (pins.cke === 1'b0 && cyc - t_cke inside {[0:1]})
      check(pins.ck_run, 1'b1);
  end

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_mode();
    int v;
    for (v = 0; v < 2; v++) begin
      @(posedge ref_clk);
      pd_slow_exit <= v[0];
      dqs_diff <= ~v[0];
      issue(CMD_MRS, `DSP_BA_MR, 1'b0);
      check(p.a[12], v[0]);
      issue(CMD_MRS, `DSP_BA_EMR, 1'b0);
      gap_min(2);
      check(p.a[10], v[0]);
      @(negedge ref_clk);
      check({slow_exit, dqs_single}, {v[0], v[0]});
    end
    $display("Mode register test finished");
  endtask

  task automatic t_column();
    issue(CMD_ACT, 2'h0, 1'b0);
    issue(CMD_WR, 2'h0, 1'b0);
    issue(CMD_RD, 2'h0, 1'b0);
    gap_min(WL + BL / 2 + WTR);
    issue(CMD_RD, 2'h0, 1'b0);
    gap_min(2);
    issue(CMD_PRE, 2'h0, 1'b0);
    gap_min(AL + ((BL / 2 > RTP) ? BL / 2 : RTP));
    issue(CMD_ACT, 2'h0, 1'b0);
    issue(CMD_WR, 2'h0, 1'b0);
    issue(CMD_PRE, 2'h0, 1'b0);
    gap_min(WL + BL / 2 + WR);
    issue(CMD_ACT, 2'h1, 1'b0);
    issue(CMD_WR, 2'h1, 1'b1);
    check(p.a[`DSP_AP_BIT], 1'b1);
    issue(CMD_ACT, 2'h1, 1'b0);
    gap_min(WL + BL / 2 + WR + RP);
    issue(CMD_PRE, 2'h0, 1'b1);
    issue(CMD_ACT, 2'h3, 1'b0);
    issue(CMD_RD, 2'h3, 1'b1);
    check(p.a[`DSP_AP_BIT], 1'b1);
    issue(CMD_ACT, 2'h3, 1'b0);
    gap_min(AL + ((BL / 2 > RTP) ? BL / 2 : RTP) + RP);
    issue(CMD_PRE, 2'h0, 1'b1);
    issue(CMD_REF, 2'h0, 1'b0);
    issue(CMD_ACT, 2'h0, 1'b0);
    gap_min(RFC);
    issue(CMD_PRE, 2'h0, 1'b1);
    $display("Column spacing test finished");
  endtask

  task automatic t_acts();
    int b;
    int t0;
    for (b = 0; b < 4; b++) begin
      issue(CMD_ACT, b[1:0], 1'b0);
      if (b == 0) t0 = t_now;
      else gap_min(2);
    end
    issue(CMD_PRE, 2'h0, 1'b1);
    issue(CMD_ACT, 2'h0, 1'b0);
    check(t_now - t0 >= FAW, 1'b1);
    issue(CMD_PRE, 2'h0, 1'b1);
    $display("Activate spacing test finished");
  endtask

  task automatic t_power_down();
    @(posedge ref_clk);
    odt_req <= 1'b1;
    issue(CMD_PDE, 2'h0, 1'b0);
    check(p.cke, 1'b0);
    check(t_now - t_odt >= 4, 1'b1);
    issue(CMD_PDX, 2'h0, 1'b0);
    check(p.cke, 1'b1);
    issue(CMD_ACT, 2'h0, 1'b0);
    gap_min(3);
    issue(CMD_PRE, 2'h0, 1'b1);
    @(posedge ref_clk);
    odt_req <= 1'b0;
    $display("Precharge power-down test finished");
  endtask

  task automatic t_active_exit();
    int s;
    for (s = 0; s < 2; s++) begin
      @(posedge ref_clk);
      pd_slow_exit <= s[0];
      issue(CMD_MRS, `DSP_BA_MR, 1'b0);
      issue(CMD_ACT, 2'h2, 1'b0);
      issue(CMD_PDE, 2'h0, 1'b0);
      issue(CMD_PDX, 2'h0, 1'b0);
      issue(CMD_RD, 2'h2, 1'b0);
      gap_min(s ? 10 - AL : 3);
      issue(CMD_PRE, 2'h0, 1'b1);
    end
    $display("Active power-down test finished");
  endtask

  task automatic t_self_refresh();
    int t_srx;
    issue(CMD_SRE, 2'h0, 1'b0);
    check(p.cke, 1'b0);
    repeat (6) @(negedge ref_clk);
    check(pins.ck_run, 1'b0);
    issue(CMD_SRX, 2'h0, 1'b0);
    t_srx = t_now;
    issue(CMD_ACT, 2'h0, 1'b0);
    check(t_now - t_srx >= XSNR, 1'b1);
    issue(CMD_RD, 2'h0, 1'b0);
    check(t_now - t_srx >= 200, 1'b1);
    issue(CMD_PRE, 2'h0, 1'b1);
    $display("Self refresh test finished");
  endtask

  task automatic t_refuse();
    issue(CMD_PDX, 2'h0, 1'b0);
    check(got_rej, 1'b1);
    issue(CMD_SRX, 2'h0, 1'b0);
    check(got_rej, 1'b1);
    issue(CMD_PDE, 2'h0, 1'b0);
    issue(CMD_ACT, 2'h0, 1'b0);
    check(got_rej, 1'b1);
    issue(CMD_PDX, 2'h0, 1'b0);
    check(got_rej, 1'b0);
    $display("Refusal test finished");
  endtask

  initial begin
    t_last = 0;
    t_now = 0;
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    odt_req = 1'b0;
    pd_slow_exit = 1'b0;
    dqs_diff = 1'b1;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    check({req_ready, done, rej, odt_sync_ok}, 4'h9);
    check(pins, {2'h3, 4'hf, 2'h0, 14'h0, 1'b0});
    t_mode();
    t_column();
    t_acts();
    t_power_down();
    t_active_exit();
    t_self_refresh();
    t_refuse();
    check(viol, 8'h00);
    finish_test();
  end
endmodule // dsp_ctrl_tb

`default_nettype wire
